// ### core/pccbr_reader.sv
// Purpose: Card reader controller with a 240-nibble column buffer.
// Assumes: All inputs synchronous to CLK_SYS; processor rereads on fault.
// Notes: Capture and unload share one column sequencer.
// Function
// [R01] Permit bit sets enable; no data interrupt otherwise
// [R02] Binary bit when idle: set mode, start pulse
// [R03] Binary mode routes nibbles straight to output
// [R04] Start pulse sets card feed request level
// [R05] Registered card motion clears the feed request
// [R06] Column strobe yields strobe, write, step, 1us apart
// [R07] Strobe loads all twelve hole bits in card read
// [R08] Strobe gives loader pulse in loader mode
// [R09] Write three nibbles high first, step after each
// [R10] Four shift pulses move next nibble up
// [R11] Count 240 sets full flag and data available in the same cycle
// [R12] Data available at step sets data interrupt
// [R13] Full count clears address and starts unload
// [R14] Unload reruns sequence, three steps per column
// [R15] Processor read strobe puts column on bus
// [R16] Interrupt per column; stop at count 240
// [R17] Buffer emptied: request next card feed
// [R18] Fault gives status interrupt, card data dropped
// [R19] Reader ready loss asserts loader halt
// [R20] Normal bit when idle: set mode, start read
// [R21] Normal mode octal-encodes bits 1-7 to eight bits
// [R22] Processor checks ready before binary read
// [R23] Low hole line stored as a one
// [R24] Several holes in 1-7 flag check bit
// [R25] Ready clears on read, sets after clean card
// [R26] Feed request held until motion and ready
// [R27] System clear resets all storage elements; the buffer nibbles have no reset
// [R28] Busy while card or unload in progress
`timescale 1ns/1ps
module pccbr_reader (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic INSTRUCTION_WRITE_STROBE,
  input wire pccbr_pkg::pccbr_ctl_s CTL_WORD,
  input wire logic PORT_INSTRUCTION_SELECT,
  input wire logic PORT_READ_STROBE_N,
  input wire logic CARD_IN_MOTION_N,
  input wire logic READER_READY_LEVEL_N,
  input wire logic READ_FAULT_N,
  input wire logic COLUMN_SAMPLE_PULSE,
  input wire logic [11:0] HOLE_DATA_N,
  input wire logic LOADER_MODE_ACTIVE_N,
  output logic CARD_FEED_REQUEST_N,
  output logic DATA_INTERRUPT_OUT_N,
  output logic STATUS_INTERRUPT_OUT_N,
  output logic [15:0] EXTERNAL_RESULT_LINES,
  output logic OUTPUT_BUS_ENABLE,
  output logic LOADER_SHIFT_PULSE,
  output logic LOADER_HALT_OUT_N,
  output logic READY_STATUS,
  output logic BUSY_STATUS
);

  localparam int DEPTH = 1 << pccbr_pkg::ADDR_W;
  localparam int STROBE_BOUND = pccbr_pkg::STEP_CYC_INT + 2;

  pccbr_pkg::pccbr_state_s q_reg;
  pccbr_pkg::pccbr_state_s q_next;
  logic [3:0] buffer_mem [0:DEPTH-1];
  logic [3:0] ram_q;
  logic buffer_write_enable;
  logic busy;
  logic start_pulse;
  logic bin_req;
  logic norm_req;
  logic phase_end;
  logic rd_fall;
  localparam int ADDR_W_LOCAL = pccbr_pkg::ADDR_W;
  logic [ADDR_W_LOCAL-1:0] addr_inc;

  // Column word for the result lines in the current mode
  function automatic logic [15:0] data_word(input logic [11:0] col,
                                            input logic normal);
    logic [2:0] oct;
    logic [2:0] holes;
    logic [15:0] w;
    oct = 3'h0;
    holes = 3'h0;
    w = pccbr_pkg::WORD_ZERO;
    for (int i = 0; i < 7; i++) begin
      if (col[i]) begin
        oct = oct | 3'(i + 1);
        holes = holes + 3'h1;
      end
    end
    if (normal) begin
      w[7:0] = {col[11:7], oct}; // [R21]
      w[pccbr_pkg::DW_CHECK_BIT] = (holes > 3'h1); // [R24]
    end else begin
      w[11:0] = col; // [R03]
    end
    return w;
  endfunction

  // Buffer read is combinational; one nibble per address
  assign ram_q = buffer_mem[q_reg.addr];
  assign addr_inc = q_reg.addr + pccbr_pkg::ADDR_ONE;
  assign phase_end = (q_reg.timer == pccbr_pkg::TIMER_ZERO);
  assign rd_fall = q_reg.rd_prev_n && !PORT_READ_STROBE_N;
  assign busy = q_reg.feed_req || q_reg.card_read_active ||
                q_reg.data_avail || (q_reg.seq != pccbr_pkg::PCCBR_IDLE);
  assign bin_req = !CTL_WORD.ctl_binary_read_bit_n;
  assign norm_req = !CTL_WORD.ctl_normal_read_bit_n;
  assign start_pulse = INSTRUCTION_WRITE_STROBE && !busy &&
                       (bin_req || norm_req); // [R28]
  assign buffer_write_enable = (q_reg.seq == pccbr_pkg::PCCBR_WRITE) &&
                               phase_end && q_reg.card_read_active; // [R09]

  // Next-state logic for the whole controller
  always_comb begin
    q_next = q_reg;
    q_next.ldr_pulse = 1'b0;
    q_next.csp_prev = COLUMN_SAMPLE_PULSE;
    q_next.rd_prev_n = PORT_READ_STROBE_N;
    q_next.card_motion_registered_n = CARD_IN_MOTION_N; // [R05]
    q_next.rdy_prev_n = READER_READY_LEVEL_N;
    if (q_reg.timer != pccbr_pkg::TIMER_ZERO) begin
      q_next.timer = q_reg.timer - 8'h01;
    end
    // Control instruction
    if (INSTRUCTION_WRITE_STROBE) begin
      q_next.interrupts_permitted =
        !CTL_WORD.ctl_interrupt_permit_bit_n; // [R01]
    end
    if (start_pulse) begin
      q_next.binary_mode_flag = bin_req; // [R02]
      q_next.normal_mode_flag = !bin_req; // [R20]
      q_next.feed_req = 1'b1; // [R04]
      q_next.card_read_active = 1'b1;
      q_next.fault = 1'b0;
      q_next.ready = 1'b0; // [R25]
    end
    // Feed request drops once the reader has taken the card
    if (q_reg.feed_req && !q_reg.card_motion_registered_n &&
        !READER_READY_LEVEL_N) begin
      q_next.feed_req = 1'b0; // [R05] [R26]
    end
    if (q_reg.card_read_active && !READ_FAULT_N) begin
      q_next.fault = 1'b1;
    end
    // Column sequencer; each timed phase lasts one step
    case (q_reg.seq)
      pccbr_pkg::PCCBR_IDLE: begin
        if ((q_reg.card_read_active && COLUMN_SAMPLE_PULSE &&
             !q_reg.csp_prev) || q_reg.fetch) begin
          q_next.seq = pccbr_pkg::PCCBR_STROBE; // [R06] [R14]
          q_next.timer = pccbr_pkg::STEP_LAST;
          q_next.fetch = 1'b0;
          q_next.nib = 2'h0;
        end
      end
      pccbr_pkg::PCCBR_STROBE: begin
        if (phase_end) begin
          q_next.ldr_pulse = !LOADER_MODE_ACTIVE_N; // [R08]
          q_next.shcnt = 3'h0;
          if (q_reg.card_read_active) begin
            q_next.sr = ~HOLE_DATA_N; // [R07] [R23]
            q_next.seq = pccbr_pkg::PCCBR_WRITE;
            q_next.timer = pccbr_pkg::STEP_LAST;
          end else begin
            q_next.seq = pccbr_pkg::PCCBR_SHIFT; // [R14]
          end
        end
      end
      pccbr_pkg::PCCBR_WRITE: begin
        if (phase_end) begin
          q_next.seq = pccbr_pkg::PCCBR_STEP;
          q_next.timer = pccbr_pkg::STEP_LAST;
        end
      end
      pccbr_pkg::PCCBR_STEP: begin
        if (phase_end) begin
          q_next.addr = addr_inc; // [R09]
          q_next.nib = q_reg.nib + 2'h1;
          q_next.shcnt = 3'h0;
          q_next.seq = pccbr_pkg::PCCBR_SHIFT;
          if (q_reg.nib == pccbr_pkg::LAST_NIB) begin
            q_next.seq = pccbr_pkg::PCCBR_IDLE;
            q_next.nib = 2'h0;
            if (q_reg.card_read_active &&
                addr_inc == pccbr_pkg::FULL_COUNT) begin
              q_next.card_read_active = 1'b0;
              q_next.addr = '0; // [R13]
              if (q_reg.fault) begin
                q_next.status_interrupt_out = 1'b1; // [R18]
              end else begin
                q_next.full_count_flag = 1'b1; // [R11]
                q_next.data_avail = 1'b1; // [R11]
                q_next.fetch = 1'b1; // [R13]
                q_next.ready = 1'b1; // [R25]
              end
            end else if (!q_reg.card_read_active && q_reg.data_avail) begin
              q_next.col_ready = 1'b1; // [R14]
              q_next.data_interrupt_out = 1'b1; // [R12] [R16]
            end
          end
        end
      end
      pccbr_pkg::PCCBR_SHIFT: begin
        // One bit per clock; buffer bits enter msb first on unload
        q_next.sr = {q_reg.sr[10:0], q_reg.card_read_active ? 1'b0 :
                     ram_q[2'(3'h3 - q_reg.shcnt)]}; // [R10]
        q_next.shcnt = q_reg.shcnt + 3'h1;
        if (q_reg.shcnt == pccbr_pkg::LAST_SHIFT) begin
          q_next.seq = pccbr_pkg::PCCBR_WRITE;
          q_next.timer = pccbr_pkg::STEP_LAST;
        end
      end
      default: begin
        q_next.seq = pccbr_pkg::PCCBR_IDLE;
      end
    endcase
    // Processor reads: status word or the assembled column
    q_next.bus_en = !PORT_READ_STROBE_N; // [R15]
    if (PORT_INSTRUCTION_SELECT) begin
      q_next.external_result_lines = pccbr_pkg::WORD_ZERO;
      q_next.external_result_lines[pccbr_pkg::ST_READY_BIT] = q_reg.ready;
      q_next.external_result_lines[pccbr_pkg::ST_TROUBLE_BIT] = q_reg.fault;
      q_next.external_result_lines[pccbr_pkg::ST_DATA_REQ_BIT] = q_reg.data_interrupt_out;
      if (rd_fall) begin
        q_next.status_interrupt_out = 1'b0;
      end
    end else begin
      q_next.external_result_lines = data_word(q_reg.sr, q_reg.normal_mode_flag); // [R15]
      if (rd_fall && q_reg.col_ready) begin
        q_next.col_ready = 1'b0;
        q_next.data_interrupt_out = 1'b0;
        if (q_reg.addr == pccbr_pkg::FULL_COUNT) begin
          q_next.data_avail = 1'b0; // [R16]
          q_next.full_count_flag = 1'b0;
          q_next.addr = '0;
          q_next.feed_req = 1'b1; // [R17]
          q_next.card_read_active = 1'b1;
          q_next.fault = 1'b0;
        end else begin
          q_next.fetch = 1'b1; // [R16]
        end
      end
    end
    // Loss of reader ready raises the halt level until ready returns
    if (!q_reg.rdy_prev_n && READER_READY_LEVEL_N) begin
      q_next.halt = 1'b1; // [R19]
    end else if (!READER_READY_LEVEL_N) begin
      q_next.halt = 1'b0;
    end
  end

  // State register; system clear restores every element
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      q_reg <= '0; // [R27]
      q_reg.seq <= pccbr_pkg::PCCBR_IDLE;
      q_reg.card_motion_registered_n <= 1'b1;
      q_reg.rdy_prev_n <= 1'b1;
      q_reg.rd_prev_n <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // Buffer nibbles; no reset, contents only valid after a capture
  always_ff @(posedge CLK_SYS) begin
    if (buffer_write_enable) begin
      buffer_mem[q_reg.addr] <= q_reg.sr[11:8]; // [R09]
    end
  end

  // Outputs, each from its own flip-flop
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      CARD_FEED_REQUEST_N <= 1'b1;
      DATA_INTERRUPT_OUT_N <= 1'b1;
      STATUS_INTERRUPT_OUT_N <= 1'b1;
      EXTERNAL_RESULT_LINES <= pccbr_pkg::WORD_ZERO;
      OUTPUT_BUS_ENABLE <= 1'b0;
      LOADER_SHIFT_PULSE <= 1'b0;
      LOADER_HALT_OUT_N <= 1'b1;
      READY_STATUS <= 1'b0;
      BUSY_STATUS <= 1'b0;
    end else begin
      CARD_FEED_REQUEST_N <= !q_next.feed_req; // [R04]
      DATA_INTERRUPT_OUT_N <=
        !(q_next.data_interrupt_out && q_next.interrupts_permitted); // [R01] [R12]
      STATUS_INTERRUPT_OUT_N <=
        !(q_next.status_interrupt_out && q_next.interrupts_permitted); // [R18]
      EXTERNAL_RESULT_LINES <= q_next.external_result_lines;
      OUTPUT_BUS_ENABLE <= q_next.bus_en;
      LOADER_SHIFT_PULSE <= q_next.ldr_pulse;
      LOADER_HALT_OUT_N <= !q_next.halt;
      READY_STATUS <= q_next.ready;
      BUSY_STATUS <= q_next.feed_req || q_next.card_read_active ||
                     q_next.data_avail ||
                     (q_next.seq != pccbr_pkg::PCCBR_IDLE);
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  a_data_interrupt_out_needs_permit: assert property ( // [R01]
    !DATA_INTERRUPT_OUT_N |-> q_reg.interrupts_permitted)
    else $error("data interrupt without permit");
  a_start_when_idle: assert property ( // [R02]
    start_pulse |=> q_reg.feed_req && q_reg.card_read_active &&
                    !CARD_FEED_REQUEST_N && !READY_STATUS)
    else $error("start did not raise feed request");
  a_shift_four_clk: assert property ( // [R10]
    $rose(q_reg.seq == pccbr_pkg::PCCBR_SHIFT) |->
      (q_reg.seq == pccbr_pkg::PCCBR_SHIFT)[*4] ##1
      (q_reg.seq == pccbr_pkg::PCCBR_WRITE))
    else $error("shift phase not four clocks");
  a_strobe_step_len: assert property ( // [R06]
    $rose(q_reg.seq == pccbr_pkg::PCCBR_STROBE) |->
      ##[1:STROBE_BOUND] (q_reg.seq != pccbr_pkg::PCCBR_STROBE))
    else $error("strobe phase too long");
  a_addr_in_range: assert property ( // [R11]
    q_reg.addr <= pccbr_pkg::FULL_COUNT)
    else $error("address past full count");
  a_full_clears_addr: assert property ( // [R13]
    $rose(q_reg.data_avail) |-> q_reg.addr == '0 && q_reg.fetch)
    else $error("unload did not start at zero");
  a_bus_on_read: assert property ( // [R15]
    !PORT_READ_STROBE_N |=> OUTPUT_BUS_ENABLE)
    else $error("bus not enabled on read");
  a_halt_on_drop: assert property ( // [R19]
    (!q_reg.rdy_prev_n && READER_READY_LEVEL_N) |=> !LOADER_HALT_OUT_N)
    else $error("halt missing on ready loss");
  a_fault_no_data: assert property ( // [R18]
    $rose(q_reg.status_interrupt_out) |-> !q_reg.data_avail && !q_reg.card_read_active)
    else $error("faulted card was unloaded");
  a_modes_exclusive: assert property ( // [R20]
    !(q_reg.binary_mode_flag && q_reg.normal_mode_flag))
    else $error("both read modes set");

endmodule

// ### shared/pccbr_pkg.sv
// Purpose: Shared constants and types for the card column buffer reader.
// Assumes: 50 MHz system clock; hole lines active low at column strobe.
// Notes: Bit n of a column (1..12) is held at index n-1 of a 12-bit word.
package pccbr_pkg;

  // Card geometry and buffer layout
  localparam int NUM_COLUMNS = 80;
  localparam int NIBS_PER_COL = 3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] FULL_COUNT = 8'hF0;
  localparam logic [7:0] ADDR_ONE = 8'h01;
  localparam logic [1:0] LAST_NIB = 2'h2;
  localparam logic [2:0] LAST_SHIFT = 3'h3;

  // Timing: one sequence step per microsecond
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_CYC_INT = (STEP_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                (STEP_TIME_NS / CLK_PERIOD_NS);
  localparam int TIMER_W = 8;
  localparam logic [TIMER_W-1:0] STEP_LAST = TIMER_W'(STEP_CYC_INT - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;

  // Word layout on the result lines
  localparam int ST_READY_BIT = 0;
  localparam int ST_TROUBLE_BIT = 2;
  localparam int ST_DATA_REQ_BIT = 15;
  localparam int DW_CHECK_BIT = 15;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [11:0] COLUMN_ZERO = 12'h000;

  // Column sequencer states, Gray coded along the capture path except shift to write
  typedef enum logic [2:0] {
    PCCBR_IDLE = 3'h0,
    PCCBR_STROBE = 3'h1,
    PCCBR_WRITE = 3'h3,
    PCCBR_STEP = 3'h2,
    PCCBR_SHIFT = 3'h6
  } pccbr_seq_e;

  // Active-low control word bits as they arrive from the processor
  typedef struct packed {
    logic ctl_interrupt_permit_bit_n;
    logic ctl_binary_read_bit_n;
    logic ctl_normal_read_bit_n;
  } pccbr_ctl_s;

  // Complete state of the reader controller
  typedef struct packed {
    pccbr_seq_e seq;
    logic [TIMER_W-1:0] timer;
    logic [2:0] shcnt;
    logic [1:0] nib;
    logic [ADDR_W-1:0] addr;
    logic [11:0] sr;
    logic interrupts_permitted;
    logic binary_mode_flag;
    logic normal_mode_flag;
    logic feed_req;
    logic card_motion_registered_n;
    logic card_read_active;
    logic data_avail;
    logic full_count_flag;
    logic fetch;
    logic col_ready;
    logic data_interrupt_out;
    logic status_interrupt_out;
    logic fault;
    logic ready;
    logic rdy_prev_n;
    logic halt;
    logic csp_prev;
    logic rd_prev_n;
    logic [15:0] external_result_lines;
    logic bus_en;
    logic ldr_pulse;
  } pccbr_state_s;

endpackage

// ### tb/pccbr_card_model.sv
// Purpose: Behavioural card reader that feeds one card per hopper load.
// Assumes: Column strobes 365 clocks apart, longer than a column sequence.
// Notes: Hole lines show the inverse pattern outside the sample window.
`timescale 1ns/1ps
module pccbr_card_model (
  input wire logic clk,
  input wire logic hopper_load,
  input wire logic feed_req_n,
  output logic card_in_motion_n,
  output logic ready_n,
  output logic col_pulse,
  output logic [11:0] hole_data_n
);
  int cards;

  // Hole pattern per column; one hole in rows 1-7 except every eighth
  function automatic logic [11:0] hole_pattern(input int c);
    logic [6:0] low;
    low = (c % 8 == 7) ? 7'h41 : 7'(1 << (c % 8));
    return {5'(c * 3), low};
  endfunction

  // Feed a card when asked and stocked; readiness follows the hopper
  initial begin
    cards = 0;
    card_in_motion_n = 1'b1;
    ready_n = 1'b1;
    col_pulse = 1'b0;
    hole_data_n = 12'hFFF;
    forever begin
      @(posedge clk);
      if (hopper_load) cards = 1;
      ready_n <= (cards == 0);
      if (!feed_req_n && !ready_n && cards != 0) begin
        cards = 0;
        card_in_motion_n <= 1'b0; // Held through all columns
        repeat (4) @(posedge clk);
        for (int c = 0; c < 80; c++) begin
          hole_data_n <= ~hole_pattern(c); // Punched hole drives low
          repeat (5) @(posedge clk);
          col_pulse <= 1'b1;
          repeat (5) @(posedge clk);
          col_pulse <= 1'b0;
          repeat (60) @(posedge clk);
          hole_data_n <= hole_pattern(c); // Inverse pattern, so a late sample reads wrong holes
          repeat (295) @(posedge clk);
        end
        card_in_motion_n <= 1'b1;
      end
    end
  end
endmodule

// ### tb/pccbr_reader_tb.sv
// Purpose: Self-checking bench for the card column buffer reader.
// Assumes: One full card per row; the reader model empties its hopper.
// Notes: The polled row reads status instead of waiting for interrupts.
`timescale 1ns/1ps
module pccbr_reader_tb;
  typedef struct packed {
    pccbr_pkg::pccbr_ctl_s ctl;
    logic normal;
    logic loader_n;
    logic [7:0] pulses;
  } pccbr_row_s;

  // Binary with interrupts, then normal polled in loader mode
  localparam pccbr_row_s ROWS [2] = '{
    '{3'h1, 1'b0, 1'b1, 8'h00},
    '{3'h6, 1'b1, 1'b0, 8'h50}
  };

  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic INSTRUCTION_WRITE_STROBE = 1'b0;
  pccbr_pkg::pccbr_ctl_s CTL_WORD = 3'h7;
  logic PORT_INSTRUCTION_SELECT = 1'b0;
  logic PORT_READ_STROBE_N = 1'b1;
  logic LOADER_MODE_ACTIVE_N = 1'b1;
  logic hopper_load = 1'b0;
  logic READ_FAULT_N = 1'b1;
  logic CARD_IN_MOTION_N, READER_READY_LEVEL_N, COLUMN_SAMPLE_PULSE;
  logic [11:0] HOLE_DATA_N;
  logic CARD_FEED_REQUEST_N, DATA_INTERRUPT_OUT_N, STATUS_INTERRUPT_OUT_N;
  logic [15:0] EXTERNAL_RESULT_LINES;
  logic OUTPUT_BUS_ENABLE, LOADER_SHIFT_PULSE, LOADER_HALT_OUT_N;
  logic READY_STATUS, BUSY_STATUS;
  logic [15:0] word;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int pulse_cnt = 0;

  always #10 CLK_SYS = ~CLK_SYS;

  pccbr_reader pccbr_reader_inst (
    .CLK_SYS, .RESET, .INSTRUCTION_WRITE_STROBE, .CTL_WORD,
    .PORT_INSTRUCTION_SELECT, .PORT_READ_STROBE_N, .CARD_IN_MOTION_N,
    .READER_READY_LEVEL_N, .READ_FAULT_N, .COLUMN_SAMPLE_PULSE,
    .HOLE_DATA_N, .LOADER_MODE_ACTIVE_N, .CARD_FEED_REQUEST_N,
    .DATA_INTERRUPT_OUT_N, .STATUS_INTERRUPT_OUT_N, .EXTERNAL_RESULT_LINES,
    .OUTPUT_BUS_ENABLE, .LOADER_SHIFT_PULSE, .LOADER_HALT_OUT_N,
    .READY_STATUS, .BUSY_STATUS
  );

  pccbr_card_model pccbr_card_model_inst (
    .clk(CLK_SYS), .hopper_load(hopper_load),
    .feed_req_n(CARD_FEED_REQUEST_N), .card_in_motion_n(CARD_IN_MOTION_N),
    .ready_n(READER_READY_LEVEL_N), .col_pulse(COLUMN_SAMPLE_PULSE),
    .hole_data_n(HOLE_DATA_N)
  );

  task automatic complete_run;
    $display("Errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Ceiling sized for two unloaded cards and one faulted card; pulse tally
  always @(posedge CLK_SYS) begin
    cycles++;
    if (LOADER_SHIFT_PULSE === 1'b1) pulse_cnt++;
    if (cycles == 170000) begin
      num_errors++;
      complete_run;
    end
  end

  task automatic check_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_word(input string name, input logic [15:0] exp,
                            input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Straight twelve bits, or octal code of rows 1-7 with rows 8-12 above
  function automatic logic [15:0] exp_word(input logic normal,
                                           input logic [11:0] h);
    logic [2:0] oct;
    int holes;
    oct = 3'h0;
    holes = 0;
    for (int i = 0; i < 7; i++) begin
      if (h[i]) begin
        oct = oct | 3'(i + 1);
        holes++;
      end
    end
    if (!normal) return {4'h0, h};
    return {holes > 1, 7'h00, h[11:7], oct};
  endfunction

  task automatic do_reset;
    RESET = 1'b1;
    repeat (3) @(negedge CLK_SYS);
    check_bit("feed_n", 1'b1, CARD_FEED_REQUEST_N);
    check_bit("halt_n", 1'b1, LOADER_HALT_OUT_N);
    check_bit("busy", 1'b0, BUSY_STATUS);
    check_word("ext", 16'h0000, EXTERNAL_RESULT_LINES);
    RESET = 1'b0;
  endtask

  task automatic write_ctl(input pccbr_pkg::pccbr_ctl_s c);
    @(negedge CLK_SYS);
    CTL_WORD = c;
    INSTRUCTION_WRITE_STROBE = 1'b1;
    @(negedge CLK_SYS);
    INSTRUCTION_WRITE_STROBE = 1'b0;
  endtask

  // Strobe held until the enabled word is taken, then released
  task automatic bus_read(input logic sel, output logic [15:0] w);
    @(negedge CLK_SYS);
    PORT_INSTRUCTION_SELECT = sel;
    PORT_READ_STROBE_N = 1'b0;
    repeat (2) @(negedge CLK_SYS);
    w = EXTERNAL_RESULT_LINES;
    check_bit("bus_en", 1'b1, OUTPUT_BUS_ENABLE);
    PORT_READ_STROBE_N = 1'b1;
  endtask

  task automatic read_col(input logic permit, input logic [15:0] exp);
    int n;
    n = 0;
    if (permit) begin
      while (DATA_INTERRUPT_OUT_N !== 1'b0 && n < 2000) begin
        @(negedge CLK_SYS);
        n++;
      end
    end else begin
      word = 16'h0000;
      while (word[15] !== 1'b1 && n < 500) begin
        bus_read(1'b1, word);
        n++;
        check_bit("data_interrupt_out_n", 1'b1, DATA_INTERRUPT_OUT_N);
      end
    end
    bus_read(1'b0, word);
    check_word("column", exp, word);
    if (permit) check_bit("data_interrupt_out_n", 1'b1, DATA_INTERRUPT_OUT_N);
  endtask

  // Rows first, then a faulted card, then a reset in the middle of a card
  initial begin
    for (int r = 0; r < 2; r++) begin
      do_reset;
      LOADER_MODE_ACTIVE_N = ROWS[r].loader_n;
      @(negedge CLK_SYS);
      hopper_load = 1'b1;
      @(negedge CLK_SYS);
      hopper_load = 1'b0;
      for (int n = 0; n < 50 && READER_READY_LEVEL_N !== 1'b0; n++)
        @(negedge CLK_SYS);
      pulse_cnt = 0;
      write_ctl(ROWS[r].ctl);
      check_bit("feed_n", 1'b0, CARD_FEED_REQUEST_N);
      check_bit("busy", 1'b1, BUSY_STATUS);
      check_bit("ready", 1'b0, READY_STATUS);
      repeat (1000) @(negedge CLK_SYS);
      write_ctl(pccbr_pkg::pccbr_ctl_s'({ROWS[r].ctl[2], ~ROWS[r].ctl[1:0]}));
      for (int n = 0; n < 32000 && CARD_IN_MOTION_N !== 1'b1; n++)
        @(negedge CLK_SYS);
      check_word("loader", {8'h00, ROWS[r].pulses}, 16'(pulse_cnt));
      for (int c = 0; c < 80; c++)
        read_col(~ROWS[r].ctl[2], exp_word(ROWS[r].normal,
                 pccbr_card_model_inst.hole_pattern(c)));
      for (int n = 0; n < 400 && CARD_FEED_REQUEST_N !== 1'b0; n++)
        @(negedge CLK_SYS);
      check_bit("feed_n", 1'b0, CARD_FEED_REQUEST_N);
      check_bit("ready", 1'b1, READY_STATUS);
      check_bit("halt_n", 1'b0, LOADER_HALT_OUT_N);
    end
    // Faulted card: status interrupt only, nothing unloaded
    do_reset;
    @(negedge CLK_SYS);
    hopper_load = 1'b1;
    @(negedge CLK_SYS);
    hopper_load = 1'b0;
    repeat (3) @(negedge CLK_SYS);
    write_ctl(3'h1);
    repeat (100) @(negedge CLK_SYS);
    READ_FAULT_N = 1'b0;
    @(negedge CLK_SYS);
    READ_FAULT_N = 1'b1;
    for (int n = 0; n < 32000 && STATUS_INTERRUPT_OUT_N !== 1'b0; n++)
      @(negedge CLK_SYS);
    check_bit("status_interrupt_out_n", 1'b0, STATUS_INTERRUPT_OUT_N);
    check_bit("data_interrupt_out_n", 1'b1, DATA_INTERRUPT_OUT_N);
    check_bit("ready", 1'b0, READY_STATUS);
    bus_read(1'b1, word);
    check_word("status", 16'h0004, word);
    check_bit("status_interrupt_out_n", 1'b1, STATUS_INTERRUPT_OUT_N);
    check_bit("busy", 1'b0, BUSY_STATUS);
    // Let the reader finish the card so it sees the next hopper load
    for (int n = 0; n < 1000 && CARD_IN_MOTION_N !== 1'b1; n++)
      @(negedge CLK_SYS);
    do_reset;
    @(negedge CLK_SYS);
    hopper_load = 1'b1;
    @(negedge CLK_SYS);
    hopper_load = 1'b0;
    repeat (3) @(negedge CLK_SYS);
    write_ctl(3'h1);
    repeat (2000) @(negedge CLK_SYS);
    do_reset;
    repeat (1000) @(negedge CLK_SYS);
    check_bit("busy", 1'b0, BUSY_STATUS);
    check_bit("data_interrupt_out_n", 1'b1, DATA_INTERRUPT_OUT_N);
    complete_run;
  end
endmodule
